// ---- inc/pcc_regs.svh ----
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// =====================================================================
// Register offsets (configuration space byte addresses)
`define PCC_OFS_REQ_LIMITS 8'he8
`define PCC_OFS_XFR_LIMIT 8'hea
`define PCC_OFS_MISS_MIN 8'hec
`define PCC_OFS_DISCARD_CLK 8'hee

// =====================================================================
// Field positions in the request limits register
`define PCC_CNT_MSB 11
`define PCC_CNT_LSB 8
`define PCC_MODE_MSB 7
`define PCC_MODE_LSB 6
`define PCC_LEN_MSB 3
`define PCC_LEN_LSB 0

// =====================================================================
// Reset values
`define PCC_RST_COUNT 4'h4
`define PCC_RST_MODE 2'h1
`define PCC_RST_LENGTH 4'h3
`define PCC_RST_XFR_LIMIT 8'h08
`define PCC_RST_MISS_MIN 12'h07f
`define PCC_RST_DISCARD_CLK 12'h1c0

// =====================================================================
// Sizes and codes
`define PCC_MIN_PREFETCH_BYTES 14'h0040
`define PCC_LEN_LAST_CODE 4'h7

`endif

// ---- inc/pcc_pkg.sv ----
package pcc_pkg;

    typedef enum logic [1:0]
    {
        PCC_MODE_NONE,
        PCC_MODE_LIGHT,
        PCC_MODE_FULL,
        PCC_MODE_RSVD
    } pcc_mode_t;

    typedef enum {PCC_EMPTY, PCC_HOLD} pcc_state_t;

endpackage : pcc_pkg

// ---- hdl/pcc_idle_timer.sv ----
`timescale 1ns/1ps

module pcc_idle_timer #(
    parameter int WIDTH = 12
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic clear_in,
    input wire logic tick_in,
    output logic [WIDTH-1:0] count_out
);

    // Refused at elaboration, so a bad width never reaches a netlist
    if (WIDTH < 1 || WIDTH > 16)
    begin : g_bad_width
        $error("pcc_idle_timer: WIDTH out of range");
    end

    wire logic at_max = &count_out;
    wire logic next_step = run_in && tick_in && !at_max;

    // Saturating so a long idle stretch never wraps back under a limit
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            count_out <= '0;
        else if (clear_in)
            count_out <= '0;
        else if (next_step)
            count_out <= count_out + 1'b1;
    end

endmodule : pcc_idle_timer

// ---- hdl/pcc_cache_ctrl.sv ----
`timescale 1ns/1ps
`include "pcc_regs.svh"

// What this block does
// - Mode 00: no prefetch; discard leftover data once any has been returned.
// - Mode 01: prefetch; discard leftover data when the master ended it.
// - Modes 01 and 10: keep leftover data when the bridge ended with retry.
// - Mode 10: prefetch and keep leftover data on master end; 11 reserved.
// - Length code 0 gives 64 bytes, doubling up to code 7 for 8 KB.
// - Miss discard only after the programmed cycle starts without a hit.
// - Miss check not triggered before the programmed minimum hit-free clocks.
// - Discard cached data after the programmed hit-free clock count.
// - Bits 5:4 of the request limits register always read as zero.
// - Upper transfer-limit bits 15:8 and timer bits 15:12 read as zero.
// - Fundamental, global and power-on resets all restore the defaults.
// - Count 0 disables auto prefetch, 1 one buffer, 2..F count-1 prefetches.
module pcc_cache_ctrl
    import pcc_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic link_fundamental_reset_n_in,
    input wire logic global_reset_input_n_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [15:0] cfg_wdata_in,
    output logic [15:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    input wire logic pci_cycle_start_in,
    input wire logic read_hit_in,
    input wire logic xfer_end_in,
    input wire logic end_by_retry_in,
    output logic prefetch_enable_out,
    output logic [13:0] prefetch_bytes_out,
    output logic [3:0] prefetch_reads_out,
    output logic cache_hold_out,
    output logic miss_check_ready_out,
    output logic discard_out
);

    // =================================================================
    // Reset: any of the three sources, released through two flops
    wire logic raw_rst_n = resetn_in && link_fundamental_reset_n_in
        && global_reset_input_n_in;
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_in or negedge raw_rst_n)
    begin
        if (!raw_rst_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // =================================================================
    // Configuration registers
    logic [3:0] prefetch_count_limit;
    pcc_mode_t completion_cache_mode;
    logic [3:0] prefetch_length_limit;
    logic [7:0] idle_cycle_start_limit;
    logic [11:0] miss_check_min;
    logic [11:0] discard_clk_limit;

    function automatic logic [3:0] pcc_decode(input logic [7:0] addr);
        pcc_decode = {addr == `PCC_OFS_DISCARD_CLK,
            addr == `PCC_OFS_MISS_MIN,
            addr == `PCC_OFS_XFR_LIMIT,
            addr == `PCC_OFS_REQ_LIMITS};
    endfunction : pcc_decode

    wire logic [3:0] wr_sel = cfg_wr_in ? pcc_decode(cfg_addr_in) : 4'h0;
    wire logic [3:0] rd_sel = pcc_decode(cfg_addr_in);

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prefetch_count_limit <= `PCC_RST_COUNT;
            completion_cache_mode <= pcc_mode_t'(`PCC_RST_MODE);
            prefetch_length_limit <= `PCC_RST_LENGTH;
            idle_cycle_start_limit <= `PCC_RST_XFR_LIMIT;
            miss_check_min <= `PCC_RST_MISS_MIN;
            discard_clk_limit <= `PCC_RST_DISCARD_CLK;
        end
        else
        begin
            if (wr_sel[0])
            begin
                prefetch_count_limit <=
                    cfg_wdata_in[`PCC_CNT_MSB:`PCC_CNT_LSB];
                completion_cache_mode <=
                    pcc_mode_t'(cfg_wdata_in[`PCC_MODE_MSB:`PCC_MODE_LSB]);
                prefetch_length_limit <=
                    cfg_wdata_in[`PCC_LEN_MSB:`PCC_LEN_LSB];
            end
            if (wr_sel[1])
                idle_cycle_start_limit <= cfg_wdata_in[7:0];
            if (wr_sel[2])
                miss_check_min <= cfg_wdata_in[11:0];
            if (wr_sel[3])
                discard_clk_limit <= cfg_wdata_in[11:0];
        end
    end

    // Reserved fields are never stored, so they read back as zero
    wire logic [15:0] rd_limits = {4'h0, prefetch_count_limit,
        completion_cache_mode, 2'b00, prefetch_length_limit};
    wire logic [15:0] next_rdata =
        rd_sel[0] ? rd_limits :
        rd_sel[1] ? {8'h00, idle_cycle_start_limit} :
        rd_sel[2] ? {4'h0, miss_check_min} :
        rd_sel[3] ? {4'h0, discard_clk_limit} : 16'h0000;

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rdata_out <= 16'h0000;
            cfg_rvalid_out <= 1'b0;
        end
        else
        begin
            cfg_rdata_out <= cfg_rd_in ? next_rdata : 16'h0000;
            cfg_rvalid_out <= cfg_rd_in;
        end
    end

    // =================================================================
    // Prefetch limits
    wire logic mode_prefetch = completion_cache_mode == PCC_MODE_LIGHT
        || completion_cache_mode == PCC_MODE_FULL;
    // Reserved length codes fall back to the smallest thread size
    wire logic [2:0] len_code = (prefetch_length_limit > `PCC_LEN_LAST_CODE)
        ? 3'h0 : prefetch_length_limit[2:0];
    wire logic [13:0] next_bytes = `PCC_MIN_PREFETCH_BYTES << len_code;
    wire logic [3:0] next_reads = (prefetch_count_limit > 4'h1)
        ? prefetch_count_limit - 4'h1 : 4'h0;
    wire logic next_pf_en = mode_prefetch
        && prefetch_count_limit != 4'h0;

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prefetch_enable_out <= 1'b0;
            prefetch_bytes_out <= 14'h0000;
            prefetch_reads_out <= 4'h0;
        end
        else
        begin
            prefetch_enable_out <= next_pf_en;
            prefetch_bytes_out <= next_bytes;
            prefetch_reads_out <= next_reads;
        end
    end

    // =================================================================
    // Leftover data: keep or discard at the end of a transfer
    pcc_state_t state;
    pcc_state_t next_state;
    logic [7:0] start_count;
    logic [11:0] clk_count;

    // Reserved mode 11 is handled like no caching
    wire logic keep_on_end = end_by_retry_in ? mode_prefetch
        : completion_cache_mode == PCC_MODE_FULL;
    wire logic holding = state == PCC_HOLD;
    wire logic timers_clear = read_hit_in || xfer_end_in || !holding;
    wire logic starts_done = start_count >= idle_cycle_start_limit;
    wire logic next_miss_ok = holding && !timers_clear
        && clk_count >= miss_check_min;
    wire logic miss_discard = next_miss_ok && starts_done;
    wire logic upper_discard = clk_count >= discard_clk_limit;
    wire logic idle_discard = holding && !timers_clear
        && (miss_discard || upper_discard);
    wire logic end_discard = xfer_end_in && !keep_on_end;
    wire logic next_discard = end_discard || idle_discard;

    always_comb
    begin
        next_state = state;
        case (state)
            PCC_EMPTY:
                if (xfer_end_in && keep_on_end)
                    next_state = PCC_HOLD;
            PCC_HOLD:
                if (next_discard)
                    next_state = PCC_EMPTY;
            default:
                next_state = PCC_EMPTY;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= PCC_EMPTY;
            cache_hold_out <= 1'b0;
            miss_check_ready_out <= 1'b0;
            discard_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cache_hold_out <= next_state == PCC_HOLD;
            miss_check_ready_out <= next_miss_ok;
            discard_out <= next_discard;
        end
    end

    // =================================================================
    // Hit-free counters
    pcc_idle_timer #(.WIDTH(8)) u_start_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .run_in(holding),
        .clear_in(timers_clear),
        .tick_in(pci_cycle_start_in),
        .count_out(start_count)
    );

    pcc_idle_timer #(.WIDTH(12)) u_clk_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .run_in(holding),
        .clear_in(timers_clear),
        .tick_in(1'b1),
        .count_out(clk_count)
    );

    // =================================================================
    // Checks
    default clocking pcc_cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    wire logic rd_limits_req = cfg_rd_in
        && cfg_addr_in == `PCC_OFS_REQ_LIMITS;
    wire logic rd_xfr_req = cfg_rd_in && cfg_addr_in == `PCC_OFS_XFR_LIMIT;

    a_none_discards: assert property (
        xfer_end_in && completion_cache_mode == PCC_MODE_NONE
        |=> discard_out && !cache_hold_out)
        else $error("mode 00 kept leftover data");
    a_light_master_end: assert property (
        xfer_end_in && !end_by_retry_in
        && completion_cache_mode == PCC_MODE_LIGHT |=> discard_out)
        else $error("light mode kept data on master end");
    a_retry_keeps: assert property (
        xfer_end_in && end_by_retry_in && mode_prefetch
        |=> cache_hold_out && !discard_out)
        else $error("retry end did not keep data");
    a_full_keeps: assert property (
        xfer_end_in && completion_cache_mode == PCC_MODE_FULL
        |=> cache_hold_out && !discard_out)
        else $error("full mode dropped data");
    // The release edge still loads reset values, so skip it
    a_length_size: assert property (
        rst_n && prefetch_length_limit <= `PCC_LEN_LAST_CODE
        |=> prefetch_bytes_out
        == (`PCC_MIN_PREFETCH_BYTES << $past(prefetch_length_limit)))
        else $error("prefetch size wrong");
    a_early_discard: assert property (
        !xfer_end_in && (start_count < idle_cycle_start_limit)
        && (clk_count < discard_clk_limit) |=> !discard_out)
        else $error("discard before cycle-start limit");
    a_miss_min_wait: assert property (
        clk_count < miss_check_min |=> !miss_check_ready_out)
        else $error("miss check before minimum clocks");
    a_upper_discard: assert property (
        holding && !read_hit_in && !xfer_end_in
        && clk_count >= discard_clk_limit |=> discard_out && !cache_hold_out)
        else $error("no discard at clock limit");
    a_rsvd_limits: assert property (
        rd_limits_req |=> cfg_rdata_out[5:4] == 2'b00
        && cfg_rdata_out[15:12] == 4'h0)
        else $error("reserved limit bits not zero");
    a_rsvd_xfr: assert property (
        rd_xfr_req |=> cfg_rdata_out[15:8] == 8'h00
        && cfg_rdata_out[7:0] == $past(idle_cycle_start_limit))
        else $error("transfer limit readback wrong");
    a_count_decode: assert property (
        prefetch_count_limit <= 4'h1 |=> prefetch_reads_out == 4'h0)
        else $error("auto prefetch reads with count 0 or 1");
    a_hit_restart: assert property (
        holding && read_hit_in |=> start_count == 8'h00
        && clk_count == 12'h000)
        else $error("counters not restarted on hit");

    c_retry_hold: cover property (xfer_end_in && end_by_retry_in
        ##1 cache_hold_out);
    c_upper_timeout: cover property (holding && upper_discard
        && !timers_clear);
    c_miss_discard: cover property (miss_discard && !upper_discard);
    c_hit_in_hold: cover property (holding && read_hit_in);

endmodule : pcc_cache_ctrl

// ---- verif/pcc_pci_master_model.sv ----
`timescale 1ns/1ps

// ==========================================================
// PCI master stand-in: cycle starts, read hits, transfer ends
module pcc_pci_master_model (
    input wire logic clk_in,
    output logic cycle_start_out,
    output logic read_hit_out,
    output logic xfer_end_out,
    output logic end_by_retry_out
);
    initial
    begin
        cycle_start_out = 1'b0;
        read_hit_out = 1'b0;
        xfer_end_out = 1'b0;
        end_by_retry_out = 1'b0;
    end

    // Kind 0 start, 1 hit, 2 end; one-cycle pulse after an edge
    task ev(input int kind, input logic retry);
        @(posedge clk_in);
        #1;
        cycle_start_out = (kind == 0);
        read_hit_out = (kind == 1);
        xfer_end_out = (kind == 2);
        end_by_retry_out = retry;
        @(posedge clk_in);
        #1;
        cycle_start_out = 1'b0;
        read_hit_out = 1'b0;
        xfer_end_out = 1'b0;
        // Qualifier is meaningless outside an end, so drive it to the inverse of retry afterwards
        end_by_retry_out = ~retry;
    endtask : ev
endmodule : pcc_pci_master_model

// ---- verif/pcc_cache_ctrl_tb_top.sv ----
`timescale 1ns/1ps

module pcc_cache_ctrl_tb_top;
    import pcc_pkg::*;
    logic clk_in;
    logic [2:0] rst_n;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic start;
    logic hit;
    logic xend;
    logic retry;
    logic pf_en;
    logic [13:0] pf_bytes;
    logic [3:0] pf_reads;
    logic hold;
    logic miss_rdy;
    logic discard;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    pcc_cache_ctrl dut (
        .clk_in(clk_in),
        .resetn_in(rst_n[0]),
        .link_fundamental_reset_n_in(rst_n[1]),
        .global_reset_input_n_in(rst_n[2]),
        .cfg_wr_in(wr),
        .cfg_rd_in(rd),
        .cfg_addr_in(addr),
        .cfg_wdata_in(wdata),
        .cfg_rdata_out(rdata),
        .cfg_rvalid_out(rvalid),
        .pci_cycle_start_in(start),
        .read_hit_in(hit),
        .xfer_end_in(xend),
        .end_by_retry_in(retry),
        .prefetch_enable_out(pf_en),
        .prefetch_bytes_out(pf_bytes),
        .prefetch_reads_out(pf_reads),
        .cache_hold_out(hold),
        .miss_check_ready_out(miss_rdy),
        .discard_out(discard)
    );

    pcc_pci_master_model pm (
        .clk_in(clk_in),
        .cycle_start_out(start),
        .read_hit_out(hit),
        .xfer_end_out(xend),
        .end_by_retry_out(retry)
    );

    // ======================================================
    // Clock, timeout and shared tasks
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            end_sim();
        end
    end

    task end_sim;
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task chk(input string name, input logic [15:0] seen,
             input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Source 0 power-on, 1 fundamental, 2 global
    task do_reset(input int src);
        @(posedge clk_in);
        #1;
        rst_n[src] = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        rst_n[src] = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
    endtask : do_reset

    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk_in);
        #1;
        wr = 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        #1;
        rd = 1'b1;
        addr = a;
        @(posedge clk_in);
        #1;
        rd = 1'b0;
        chk("rvalid", {15'h0, rvalid}, 16'h0001);
        chk("rdata", rdata, exp);
    endtask : rd_chk

    // Edges from the current sample point until the discard pulse
    task wait_discard(output int cnt);
        cnt = 0;
        while (discard !== 1'b1 && cnt < 1000)
        begin
            @(posedge clk_in);
            #1;
            cnt++;
        end
    endtask : wait_discard

    // ======================================================
    // Scenarios
    task t_regs;
        for (int s = 0; s < 3; s++)
        begin
            wr_reg(8'hea, 16'h0055);
            wr_reg(8'he8, 16'h0000);
            do_reset(s);
            rd_chk(8'he8, 16'h0443);
            rd_chk(8'hea, 16'h0008);
            rd_chk(8'hec, 16'h007f);
            rd_chk(8'hee, 16'h01c0);
            chk("bytes", {2'h0, pf_bytes}, 16'h0200);
        end
        rd_chk(8'he0, 16'h0000);
        wr_reg(8'he8, 16'hffff);
        wr_reg(8'hea, 16'hffff);
        wr_reg(8'hec, 16'hffff);
        wr_reg(8'hee, 16'hffff);
        rd_chk(8'he8, 16'h0fcf);
        rd_chk(8'hea, 16'h00ff);
        rd_chk(8'hec, 16'h0fff);
        rd_chk(8'hee, 16'h0fff);
    endtask : t_regs

    // Count and length share the code c; every mode is swept
    task t_prefetch;
        logic [3:0] c;
        logic [1:0] m;
        for (int i = 0; i < 64; i++)
        begin
            c = i[3:0];
            m = i[5:4];
            wr_reg(8'he8, {4'h0, c, m, 2'b00, c});
            repeat (2) @(posedge clk_in);
            #1;
            chk("bytes", {2'h0, pf_bytes},
                (c < 8) ? 16'h0040 << c : 16'h0040);
            chk("en", {15'h0, pf_en},
                {15'h0, (m == 1 || m == 2) && c != 0});
            chk("reads", {12'h0, pf_reads},
                {12'h0, (c >= 2) ? c - 4'h1 : 4'h0});
        end
    endtask : t_prefetch

    task t_modes;
        logic keep;
        for (int i = 0; i < 8; i++)
        begin
            do_reset(2);
            wr_reg(8'he8, {8'h04, i[2:1], 6'h03});
            keep = (i[2:1] == 2) || (i[2:1] == 1 && i[0]);
            pm.ev(2, i[0]);
            chk("hold", {15'h0, hold}, {15'h0, keep});
            chk("discard", {15'h0, discard}, {15'h0, !keep});
        end
    endtask : t_modes

    task t_timers;
        do_reset(1);
        pm.ev(2, 1'b1);
        wait_discard(n);
        chk("upper_n", n[15:0], 16'd449);
        chk("hold", {15'h0, hold}, 16'h0000);
        wr_reg(8'hee, 16'h0020);
        pm.ev(2, 1'b1);
        repeat (20) @(posedge clk_in);
        pm.ev(1, 1'b0);
        wait_discard(n);
        chk("hit_n", n[15:0], 16'd33);
        wr_reg(8'hea, 16'h0003);
        wr_reg(8'hec, 16'h0010);
        wr_reg(8'hee, 16'h0fff);
        pm.ev(2, 1'b1);
        chk("miss_rdy", {15'h0, miss_rdy}, 16'h0000);
        repeat (100) @(posedge clk_in);
        #1;
        chk("miss_rdy", {15'h0, miss_rdy}, 16'h0001);
        chk("hold", {15'h0, hold}, 16'h0001);
        repeat (3) pm.ev(0, 1'b0);
        wait_discard(n);
        chk("starts_n", n[15:0], 16'd1);
        // Starts done early; discard waits for the clock minimum
        pm.ev(2, 1'b1);
        repeat (3) pm.ev(0, 1'b0);
        wait_discard(n);
        chk("min_n", n[15:0], 16'd11);
    endtask : t_timers

    initial
    begin
        rst_n = 3'b110;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        do_reset(0);
        t_regs();
        t_prefetch();
        t_modes();
        t_timers();
        end_sim();
    end
endmodule : pcc_cache_ctrl_tb_top
